/* File: verilog/csi_pkg.sv */
package csi_pkg;

    // ------------------------------------------------------------
    // Bus geometry and register offsets.
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 4;
    localparam logic [5:0] OFF_PIN_FUNC = 6'h04;
    localparam logic [5:0] OFF_CTRL_PRI = 6'h05;
    localparam logic [5:0] OFF_DATA_LO = 6'h06;
    localparam logic [5:0] OFF_DATA_HI = 6'h07;
    localparam logic [5:0] OFF_MISC = 6'h0c;
    localparam logic [5:0] OFF_STATUS = 6'h23;
    localparam logic [5:0] OFF_CTRL_SEC = 6'h28;
    localparam logic [5:0] OFF_IRQ_CLR = 6'h2c;
    localparam logic [5:0] OFF_IRQ_EN = 6'h2d;
    localparam logic [5:0] OFF_START = 6'h2e;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int PRI_PIN_BIT = 3;
    localparam int SEC_DIV_BIT = 0;
    localparam int SEC_IDLE_BIT = 1;
    localparam int MISC_PULLUP_BIT = 3;
    localparam int PIN_TX_BIT = 0;
    localparam int PIN_RX_BIT = 1;
    localparam int ST_XFER_BIT = 0;
    localparam int ST_WAIT_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_ABORT_BIT = 3;

    // ------------------------------------------------------------
    // Reset values, codes and timing.
    // ------------------------------------------------------------
    localparam logic [1:0] RST_PIN_FUNC = 2'h0;
    localparam logic [3:0] RST_CTRL_PRI = 4'h0;
    localparam logic [3:0] RST_MISC = 4'h0;
    localparam logic RST_DIV_SEL = 1'b0;
    localparam logic RST_IDLE_LVL = 1'b0;
    localparam logic [3:0] RST_IRQ_EN = 4'h0;
    localparam logic [2:0] CLK_CODE_SYS = 3'h6;
    localparam logic [2:0] CLK_CODE_EXT = 3'h7;
    localparam logic [1:0] PIN_MODE_CONT = 2'h0;
    localparam logic [2:0] FRAME_LAST = 3'h7;
    localparam logic [1:0] CTRL_DELAY = 2'h2;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TCYC_NS = 25;
    localparam int TCYC_CYCLES = (TCYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_SHIFT_TOP = 11;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLKWAIT,
        ST_XFER,
        ST_CONT
    } csi_state_e;

endpackage

/* File: verilog/csi_tick_if.sv */
`timescale 1ns/1ps
// Transmit clock edge events shared by the generator, shifter and control.
interface csi_tick_if;
    logic fall;
    logic rise;
    logic active;
    modport src (output fall, output rise);
    modport dst (input fall, input rise, input active);
    modport ctl (input fall, input rise, output active);
endinterface

/* File: verilog/csi_clkgen.sv */
`timescale 1ns/1ps
module csi_clkgen
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic ext_mode,
    input wire logic sck_sync,
    input wire logic [2:0] code,
    input wire logic div_sel,
    csi_tick_if.src tick
);
    import csi_pkg::*;

    logic [12:0] cnt_q;
    logic [12:0] half;
    logic [3:0] shift_amt;
    logic phase_q;
    logic ext_prev_q;

    // ------------------------------------------------------------
    // Half period in clock cycles.
    // ------------------------------------------------------------
    // The extra divide by two doubles every prescaler half period.
    always_comb begin
        shift_amt = 4'(HALF_SHIFT_TOP) - {code, 1'b0} + {3'h0, div_sel};
        if (code == CLK_CODE_SYS) begin
            half = 13'(TCYC_CYCLES);
        end else begin
            half = 13'(TCYC_CYCLES) << shift_amt;
        end
    end

    // Internal clock: idles high and restarts its phase whenever stopped.
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            cnt_q <= 13'h0;
            phase_q <= 1'b1;
        end else if (cnt_q == half - 13'h1) begin
            cnt_q <= 13'h0;
            phase_q <= !phase_q;
        end else begin
            cnt_q <= cnt_q + 13'h1;
        end
    end

    // Previous synchronised pin level, for edge detection in external mode.
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= sck_sync;
        end
    end

    // Edge events as one-cycle pulses.
    always_comb begin
        if (ext_mode) begin
            tick.fall = ext_prev_q && !sck_sync;
            tick.rise = !ext_prev_q && sck_sync;
        end else begin
            tick.fall = run && phase_q && (cnt_q == half - 13'h1);
            tick.rise = run && !phase_q && (cnt_q == half - 13'h1);
        end
    end

endmodule

/* File: verilog/csi_shifter.sv */
`timescale 1ns/1ps
module csi_shifter
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic load_lo,
    input wire logic load_hi,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic rx_bit,
    csi_tick_if.dst tick,
    output logic [7:0] data
);
    import csi_pkg::*;

    // The data register has no reset value, so software loads it before a frame.
    // Receive data enters at the top so the first bit ends up at bit 0.
    always_ff @(posedge clk) begin
        if (tick.active && tick.rise) begin
            data <= {rx_bit, data[7:1]};
        end else if (load_lo) begin
            data[3:0] <= wdata;
        end else if (load_hi) begin
            data[7:4] <= wdata;
        end
    end

endmodule

/* File: verilog/csi_top.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Contract
// - Ending a frame by control write or start during the first low clock pulse sets no done flag.
// - Any primary control write stops the clock and clears the bit counter; after the first low clock pulse it also flags an interrupted frame.
// - A primary control value takes effect two cycles after the write; software waits before starting.
// - Clock codes 0 to 5 pick the prescaler, code 6 the system clock, and both drive the clock pin when primary bit 3 is set.
// - Secondary bit 0 divides the prescaler by a further 2 and is reset together with secondary bit 1.
// - In idle states secondary bit 1 sets the data-out level at once when written.
// - Data leaves LSB first on falling clock edges and enters LSB first on rising edges.
// - Misc bit 3 turns the data-out pull-up on, the register being write-only and reset to zero.
// - With the clock pin function, pin bits pick continuous clock (codes 0 to 6 only), transmit, receive or both.
// - Start clears the counter, rising edges count, the eighth edge or an abort flags, and a control write or an internal eighth edge stops.
module csi_top
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [csi_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [csi_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [csi_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe,
    output logic so_pullup,
    output logic irq
);
    import csi_pkg::*;

    // ------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------
    csi_tick_if tick ();
    csi_state_e state_q;
    logic [1:0] pin_func_q;
    logic [3:0] ctrl_pend_q;
    logic [3:0] ctrl_q;
    logic [1:0] ctrl_wait_q;
    logic div_sel_q;
    logic idle_lvl_q;
    logic [3:0] misc_q;
    logic [3:0] stat_q;
    logic [3:0] irq_en_q;
    logic [2:0] bit_cnt_q;
    logic sck_meta_q;
    logic sck_sync_q;
    logic si_meta_q;
    logic si_sync_q;
    logic [7:0] sh_data;
    logic wr_pri;
    logic wr_sec;
    logic start_cmd;
    logic pin_is_sck;
    logic int_mode;
    logic gen_run;
    logic idle_state;
    logic frame_done;
    logic frame_abort;
    logic [3:0] stat_set;
    logic [3:0] stat_clr;
    logic [3:0] state_bits;

    // ------------------------------------------------------------
    // Decode and mode.
    // ------------------------------------------------------------
    assign wr_pri = reg_wr && (reg_addr == OFF_CTRL_PRI);
    assign wr_sec = reg_wr && (reg_addr == OFF_CTRL_SEC);
    assign start_cmd = reg_wr && (reg_addr == OFF_START);
    assign pin_is_sck = ctrl_q[PRI_PIN_BIT];
    assign int_mode = pin_is_sck && (ctrl_q[2:0] != CLK_CODE_EXT);
    assign idle_state = (state_q == ST_IDLE) || (state_q == ST_CLKWAIT);
    assign gen_run = int_mode && !idle_state || int_mode && (state_q == ST_CLKWAIT);
    assign tick.active = (state_q == ST_XFER);

    // A frame ends on the eighth rising edge or on an abort while transferring.
    // During the first low pulse the counter is still zero, so no flag is raised.
    assign frame_done = (state_q == ST_XFER) && tick.rise && (bit_cnt_q == FRAME_LAST);
    assign frame_abort = (state_q == ST_XFER) && (wr_pri || start_cmd) && (bit_cnt_q != 3'h0);

    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    // Both pins come from outside and pass two flops before any use.
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_meta_q <= 1'b1;
            sck_sync_q <= 1'b1;
            si_meta_q <= 1'b0;
            si_sync_q <= 1'b0;
        end else begin
            sck_meta_q <= sck_i;
            sck_sync_q <= sck_meta_q;
            si_meta_q <= si_i;
            si_sync_q <= si_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Submodules.
    // ------------------------------------------------------------
    csi_clkgen u_clkgen (
        .clk(clk),
        .reset(reset),
        .run(gen_run),
        .ext_mode(!int_mode),
        .sck_sync(sck_sync_q),
        .code(ctrl_q[2:0]),
        .div_sel(div_sel_q),
        .tick(tick.src)
    );

    csi_shifter u_shifter (
        .clk(clk),
        .load_lo(reg_wr && (reg_addr == OFF_DATA_LO)),
        .load_hi(reg_wr && (reg_addr == OFF_DATA_HI)),
        .wdata(reg_wdata),
        .rx_bit(pin_func_q[PIN_RX_BIT] && si_sync_q),
        .tick(tick.dst),
        .data(sh_data)
    );

    // ------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------
    // Pin function and misc registers are write-only and reset to zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_func_q <= RST_PIN_FUNC;
            misc_q <= RST_MISC;
            irq_en_q <= RST_IRQ_EN;
        end else if (reg_wr) begin
            if (reg_addr == OFF_PIN_FUNC) begin
                pin_func_q <= reg_wdata[1:0];
            end
            if (reg_addr == OFF_MISC) begin
                misc_q <= reg_wdata;
            end
            if (reg_addr == OFF_IRQ_EN) begin
                irq_en_q <= reg_wdata;
            end
        end
    end

    // The primary value waits two cycles, so a start issued too early still
    // runs with the previous clock choice.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_pend_q <= RST_CTRL_PRI;
            ctrl_q <= RST_CTRL_PRI;
            ctrl_wait_q <= 2'h0;
        end else if (wr_pri) begin
            ctrl_pend_q <= reg_wdata;
            ctrl_wait_q <= CTRL_DELAY - 2'h1;
        end else if (ctrl_wait_q != 2'h0) begin
            ctrl_wait_q <= ctrl_wait_q - 2'h1;
            if (ctrl_wait_q == 2'h1) begin
                ctrl_q <= ctrl_pend_q;
            end
        end
    end

    // The divide select and the idle level are both reset to fixed start values.
    always_ff @(posedge clk) begin
        if (reset) begin
            div_sel_q <= RST_DIV_SEL;
            idle_lvl_q <= RST_IDLE_LVL;
        end else if (wr_sec) begin
            div_sel_q <= reg_wdata[SEC_DIV_BIT];
            idle_lvl_q <= reg_wdata[SEC_IDLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Transfer state machine.
    // ------------------------------------------------------------
    // A control write wins over start and over clock edges in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
        end else if (wr_pri) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
        end else if (start_cmd) begin
            state_q <= ST_CLKWAIT;
            bit_cnt_q <= 3'h0;
        end else begin
            case (state_q)
                ST_CLKWAIT: begin
                    if (tick.fall && pin_is_sck) begin
                        if (int_mode && (pin_func_q == PIN_MODE_CONT)) begin
                            state_q <= ST_CONT;
                        end else begin
                            state_q <= ST_XFER;
                        end
                    end
                end
                ST_XFER: begin
                    if (tick.rise) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == FRAME_LAST) begin
                            state_q <= int_mode ? ST_IDLE : ST_CLKWAIT;
                        end
                    end
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_CONT: begin
                    state_q <= ST_CONT;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers.
    // ------------------------------------------------------------
    // The clock pin is an output for every internal source when primary bit 3 is set, and idles high.
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_o <= 1'b1;
            sck_oe <= 1'b0;
        end else begin
            sck_oe <= int_mode;
            if (!gen_run) begin
                sck_o <= 1'b1;
            end else if (tick.fall) begin
                sck_o <= 1'b0;
            end else if (tick.rise) begin
                sck_o <= 1'b1;
            end
        end
    end

    // Data out takes the idle level when it is written in idle states and the frame on falling edges.
    // The idle level cannot be changed once a frame is running.
    always_ff @(posedge clk) begin
        if (reset) begin
            so_o <= RST_IDLE_LVL;
            so_oe <= 1'b0;
            so_pullup <= 1'b0;
        end else begin
            so_oe <= pin_func_q[PIN_TX_BIT];
            so_pullup <= misc_q[MISC_PULLUP_BIT];
            if (wr_sec && idle_state) begin
                so_o <= reg_wdata[SEC_IDLE_BIT];
            end else if (tick.fall && pin_is_sck && (state_q == ST_XFER || state_q == ST_CLKWAIT)
                         && !(int_mode && pin_func_q == PIN_MODE_CONT)) begin
                so_o <= sh_data[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and read data.
    // ------------------------------------------------------------
    assign stat_set = {frame_abort, frame_done || frame_abort, 2'h0};
    assign stat_clr = (reg_wr && reg_addr == OFF_IRQ_CLR) ? reg_wdata : 4'h0;
    assign state_bits = {2'h0, state_q == ST_CLKWAIT, state_q == ST_XFER};

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
            irq <= |(stat_q & irq_en_q);
        end
    end

    // Write-only and unmapped addresses read as zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 4'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_DATA_LO: reg_rdata <= sh_data[3:0];
                OFF_DATA_HI: reg_rdata <= sh_data[7:4];
                OFF_STATUS: reg_rdata <= stat_q | state_bits;
                OFF_IRQ_EN: reg_rdata <= irq_en_q;
                default: reg_rdata <= 4'h0;
            endcase
        end else begin
            reg_rdata <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_pri_write_alone;
        wr_pri ##1 !wr_pri;
    endsequence

    sequence s_last_edge;
        (state_q == ST_XFER) && tick.rise && (bit_cnt_q == FRAME_LAST) && !wr_pri && !start_cmd;
    endsequence

    a_pri_write_idle: assert property (wr_pri |=> state_q == ST_IDLE && bit_cnt_q == 3'h0)
        else $error("control write did not stop the frame");
    a_abort_flag_set: assert property (frame_abort |=> stat_q[ST_DONE_BIT] && stat_q[ST_ABORT_BIT])
        else $error("interrupted frame left flags clear");
    a_first_low_quiet: assert property ((state_q == ST_XFER) && (bit_cnt_q == 3'h0) && (wr_pri || start_cmd)
        && !stat_q[ST_DONE_BIT] |=> !stat_q[ST_DONE_BIT])
        else $error("flag raised in first low pulse");
    a_ctrl_delay_two: assert property (s_pri_write_alone |-> ##1 ctrl_q == $past(reg_wdata, 2))
        else $error("control value not active after two cycles");
    a_ctrl_not_early: assert property (wr_pri |=> $stable(ctrl_q))
        else $error("control value took effect too early");
    a_eighth_edge_done: assert property (s_last_edge |=> stat_q[ST_DONE_BIT] && bit_cnt_q == 3'h0)
        else $error("frame end not flagged");
    a_idle_level_now: assert property (wr_sec && idle_state |=> so_o == $past(reg_wdata[SEC_IDLE_BIT]))
        else $error("idle level not applied");
    a_pullup_follows: assert property (reg_wr && reg_addr == OFF_MISC
        |-> ##2 so_pullup == $past(reg_wdata[MISC_PULLUP_BIT], 2))
        else $error("pull-up does not follow misc bit");
    a_sck_drives_out: assert property (int_mode |=> sck_oe)
        else $error("clock pin not driven in internal mode");
    a_cont_entry: assert property ((state_q == ST_CLKWAIT) && tick.fall && int_mode && !wr_pri && !start_cmd
        && pin_func_q == PIN_MODE_CONT |=> state_q == ST_CONT)
        else $error("continuous clock mode not entered");

endmodule

/* File: verification/csi_peer.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial peer on the far side of the clock and data lines.
// ------------------------------------------------------------
module csi_peer (
    input wire logic clk,
    input wire logic sck,
    input wire logic so,
    input wire logic arm,
    input wire logic [7:0] tx_byte,
    output logic si,
    output logic [7:0] rx_byte,
    output logic [7:0] rises
);
    logic [2:0] idx;

    // Start from a known line level so the first sample is never unknown.
    initial begin
        si = 1'b0;
        rx_byte = 8'h00;
        rises = 8'h00;
        idx = 3'h0;
    end

    // Arming restarts the bit position for a new frame.
    always @(posedge arm) begin
        rises = 8'h00;
        idx = 3'h0;
    end

    // Next bit goes out after each fall, LSB first, the way the device expects it.
    always @(negedge sck) begin
        if (rises < 8'h08) si = tx_byte[idx];
    end

    // After eight rises the line is not held, so it wanders instead of keeping the last bit.
    always @(posedge clk) begin
        if (rises >= 8'h08) si <= ~si;
    end

    // Data-out is captured on each rise, LSB first.
    always @(posedge sck) begin
        rx_byte = {so, rx_byte[7:1]};
        rises = rises + 8'h01;
        idx = idx + 3'h1;
    end
endmodule

/* File: verification/csi_top_test.sv */
`timescale 1ns/1ps
module csi_top_test;
    import csi_pkg::*;
    logic clk, reset, reg_wr, reg_rd, si_i, sck_i, sck_o, sck_oe, so_o, so_oe, so_pullup, irq, arm, ext_sck;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [7:0] ptx, prx, rises, tx, pb, d, lo;
    logic [2:0] code;
    int seed, miscompares, cmp_count, cycles;
    time t0;

    csi_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .si_i(si_i),
        .so_o(so_o), .so_oe(so_oe), .so_pullup(so_pullup), .irq(irq));
    csi_peer peer (.clk(clk), .sck(sck_i), .so(so_o), .arm(arm), .tx_byte(ptx), .si(si_i), .rx_byte(prx),
        .rises(rises));

    // The clock pin follows the far-side source, which idles high, whenever the block leaves it undriven.
    assign sck_i = sck_oe ? sck_o : ext_sck;

    // ------------------------------------------------------------
    // Clock, bus tasks and checking.
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wr(input logic [5:0] a, input logic [3:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = {4'h0, reg_rdata};
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Polling the status only is safe mid-frame; the data register is left alone.
    task automatic wait_done(input int n);
        d = 8'h00;
        for (int k = 0; k < n && d[ST_DONE_BIT] !== 1'b1; k++) rd(OFF_STATUS, d);
    endtask

    task automatic start_frame(input logic [7:0] b);
        ptx <= b;
        arm <= 1'b1;
        wr(OFF_START, 4'h0);
        arm <= 1'b0;
    endtask

    // Full clock period in cycles for a clock code and extra divide.
    function automatic int exp_period(input logic [2:0] c, input logic dv);
        return (c == CLK_CODE_SYS) ? 2 : 2 << (11 - 2 * int'(c) + int'(dv));
    endfunction

    // A hang is cut short and reported as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        seed = 52;
        {reset, reg_wr, reg_rd, arm, ext_sck} = 5'b10001;
        reg_addr = 6'h00;
        reg_wdata = 4'h0;
        ptx = 8'h00;
        cycles = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1 chk("sck_oe", 8'h00, 8'(sck_oe));
        chk("so_pullup", 8'h00, 8'(so_pullup));
        rd(OFF_MISC, d);
        chk("misc_read", 8'h00, d);
        rd(6'h3f, d);
        chk("unmapped", 8'h00, d);
        wr(OFF_MISC, 4'h8);
        repeat (3) @(posedge clk);
        #1 chk("so_pullup", 8'h01, 8'(so_pullup));
        wr(OFF_PIN_FUNC, 4'h1);
        wr(OFF_CTRL_PRI, 4'h4); // Primary rewritten after a pin change.
        repeat (3) @(posedge clk);
        #1 chk("sck_oe_port", 8'h00, 8'(sck_oe));
        chk("so_oe", 8'h01, 8'(so_oe));
        for (int v = 1; v >= 0; v--) begin
            wr(OFF_CTRL_SEC, 4'(2 * v));
            #1 chk("idle_level", 8'(v), 8'(so_o));
        end
        // Full-duplex frames over several clock codes and divides; interrupt stays masked.
        for (int i = 0; i < 5; i++) begin
            code = (i < 2) ? 3'h4 : (i < 4) ? 3'h3 : CLK_CODE_SYS;
            tx = 8'($random(seed));
            pb = 8'($random(seed));
            wr(OFF_CTRL_SEC, {3'h0, i[0]}); // Divide select between frames only.
            wr(OFF_PIN_FUNC, 4'h3);
            wr(OFF_CTRL_PRI, {1'b1, code});
            repeat (2) @(posedge clk);
            wr(OFF_DATA_LO, tx[3:0]);
            wr(OFF_DATA_HI, tx[7:4]);
            start_frame(pb);
            @(negedge sck_o);
            t0 = $time;
            #1 chk("sck_oe", 8'h01, 8'(sck_oe));
            @(negedge sck_o);
            chk("period", 8'(exp_period(code, i[0])), 8'(($time - t0) / 25));
            wait_done(600);
            chk("done", 8'h04, d & 8'h04);
            chk("peer_rx", tx, prx);
            chk("rises", 8'h08, rises);
            chk("irq_masked", 8'h00, 8'(irq));
            rd(OFF_DATA_LO, lo);
            rd(OFF_DATA_HI, d);
            if (code != CLK_CODE_SYS) chk("rx_data", pb, {d[3:0], lo[3:0]});
            wr(OFF_IRQ_CLR, 4'hc);
        end
        // Abort in mid-frame with the clock pin confirmed high sets the flag and stops the clock.
        wr(OFF_IRQ_EN, 4'h4);
        rd(OFF_IRQ_EN, d);
        chk("irq_en", 8'h04, d);
        wr(OFF_CTRL_PRI, 4'hc);
        repeat (2) @(posedge clk);
        start_frame(8'($random(seed)));
        wait (rises == 8'h03);
        wait (sck_i == 1'b1);
        wr(OFF_CTRL_PRI, 4'hc);
        repeat (40) @(posedge clk);
        chk("stopped", 8'h03, rises);
        rd(OFF_STATUS, d);
        chk("abort_done", 8'h04, d & 8'h04);
        chk("irq", 8'h01, 8'(irq));
        wr(OFF_IRQ_CLR, 4'hc);
        repeat (2) @(posedge clk);
        #1 chk("irq_clr", 8'h00, 8'(irq));
        // An abort in the first low pulse leaves the flag clear.
        repeat (2) @(posedge clk);
        start_frame(8'($random(seed)));
        @(negedge sck_o);
        wr(OFF_CTRL_PRI, 4'hc);
        rd(OFF_STATUS, d);
        chk("early_abort", 8'h00, d & 8'h04);
        // Continuous clock with both pin bits clear runs past eight clocks with no flag.
        wr(OFF_PIN_FUNC, 4'h0);
        wr(OFF_CTRL_PRI, 4'hc);
        repeat (2) @(posedge clk);
        start_frame(8'h00);
        repeat (400) @(posedge clk);
        chk("cont_run", 8'h01, 8'(rises > 8'h10));
        rd(OFF_STATUS, d);
        chk("cont_flag", 8'h00, d & 8'h04);
        wr(OFF_CTRL_PRI, 4'h4);
        // External clock: eight slow pulses come from the far side while the pin stays undriven.
        wr(OFF_PIN_FUNC, 4'h3);
        wr(OFF_CTRL_PRI, 4'hf);
        repeat (2) @(posedge clk);
        tx = 8'($random(seed));
        pb = 8'($random(seed));
        wr(OFF_DATA_LO, tx[3:0]);
        wr(OFF_DATA_HI, tx[7:4]);
        start_frame(pb);
        repeat (16) begin
            repeat (8) @(posedge clk);
            ext_sck <= ~ext_sck;
        end
        wait_done(20);
        chk("ext_done", 8'h04, d & 8'h04);
        chk("ext_sck_oe", 8'h00, 8'(sck_oe));
        chk("ext_peer_rx", tx, prx);
        chk("ext_rises", 8'h08, rises);
        rd(OFF_DATA_LO, lo);
        rd(OFF_DATA_HI, d);
        chk("ext_rx_data", pb, {d[3:0], lo[3:0]});
        print_verdict();
    end
endmodule
